// *** rtl/cfsp_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfsp_top import cfsp_pkg::*; (
    input wire logic CLOCK_IN,
    input wire logic RESET_N_IN,
    input wire logic OP_VALID_IN,
    input wire cfsp_op_t OP_CODE_IN,
    input wire logic [7:0] OPERAND_A_IN,
    input wire logic [7:0] OPERAND_B_IN,
    input wire cfsp_ctx_t CTX_IN,
    input wire logic [IRQ_COUNT-1:0] IRQ_IN,
    input wire logic TRAP_IN,
    output logic OP_READY_OUT,
    output logic OP_DONE_OUT,
    output logic [7:0] RESULT_OUT,
    output logic [7:0] FLAGS_OUT,
    output logic [15:0] STACK_POINTER_OUT,
    output logic [7:0] POP_DATA_OUT,
    output cfsp_ctx_t CTX_OUT,
    output logic CTX_VALID_OUT,
    output logic INT_ENTRY_OUT,
    output logic [3:0] INT_VECTOR_OUT,
    output logic [IRQ_COUNT-1:0] PENDING_OUT
);
    logic [1:0] rst_sync_reg;
    logic rst_n;

    cfsp_seq_t state_reg;
    cfsp_seq_t state_next;
    cfsp_kind_t kind_reg;
    cfsp_kind_t kind_next;
    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic [39:0] push_buf_reg;
    logic [39:0] push_buf_next;
    logic [39:0] pop_buf_reg;
    logic [39:0] pop_buf_next;
    logic [3:0] vector_reg;
    logic [3:0] vector_next;
    logic done_reg;
    logic done_next;
    logic ctx_valid_reg;
    logic ctx_valid_next;
    logic int_entry_reg;
    logic int_entry_next;
    logic [IRQ_COUNT-1:0] pending_reg;
    logic [IRQ_COUNT-1:0] pending_next;
    logic trap_reg;
    logic trap_next;

    logic [IRQ_COUNT-1:0] clear_mask;
    logic [IRQ_COUNT-1:0] pend_onehot;
    logic [3:0] int_vector;
    logic trap_clear;
    logic take_int;
    logic accept;
    logic op_is_alu;
    logic flags_load;
    logic [7:0] flags_val;
    logic mask_set;
    logic stack_push;
    logic stack_pop;
    logic stack_reload;
    logic stack_load_low;
    logic [7:0] stack_wdata;
    logic [7:0] stack_rdata;
    logic half_add;

    // Reset release through two flip-flops
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Pending requests; lowest line wins, trap ignores the mask
    always_comb begin
        int_vector = TRAP_VECTOR;
        pend_onehot = '0;
        if (!trap_reg) begin
            for (int k = IRQ_COUNT - 1; k >= 0; k--) begin
                if (pending_reg[k]) begin
                    int_vector = 4'(k);
                    pend_onehot = '0;
                    pend_onehot[k] = 1'b1;
                end
            end
        end
    end

    assign take_int = (state_reg == SEQ_IDLE)
        && (trap_reg || ((|pending_reg) && !FLAGS_OUT[FLAG_I]));
    assign OP_READY_OUT = (state_reg == SEQ_IDLE) && !take_int;
    assign accept = OP_VALID_IN && OP_READY_OUT;
    assign op_is_alu = (OP_CODE_IN <= OP_DISABLE_INT);

    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        count_next = count_reg;
        push_buf_next = push_buf_reg;
        pop_buf_next = pop_buf_reg;
        vector_next = vector_reg;
        done_next = 1'b0;
        ctx_valid_next = 1'b0;
        int_entry_next = 1'b0;
        clear_mask = '0;
        trap_clear = 1'b0;
        flags_load = 1'b0;
        flags_val = pop_buf_reg[7:0];
        mask_set = 1'b0;
        unique case (state_reg)
            SEQ_IDLE: begin
                if (take_int) begin
                    state_next = SEQ_PUSH;
                    kind_next = KIND_INT;
                    count_next = INT_BYTES;
                    // Return low byte goes first; second index register is not saved
                    push_buf_next = {CTX_IN.pc[7:0], CTX_IN.pc[15:8], CTX_IN.x, CTX_IN.a,
                                     FLAGS_OUT};
                    vector_next = int_vector;
                    trap_clear = trap_reg;
                    clear_mask = pend_onehot;
                end else if (accept) begin
                    done_next = op_is_alu || OP_CODE_IN == OP_STACK_RELOAD
                        || OP_CODE_IN == OP_STACK_LOAD_LOW;
                    pop_buf_next = '0;
                    unique case (OP_CODE_IN)
                        OP_PUSH: begin
                            state_next = SEQ_PUSH;
                            kind_next = KIND_PUSH;
                            count_next = ONE_BYTE;
                            push_buf_next = {OPERAND_A_IN, 32'h0};
                        end
                        OP_PUSH_FLAGS: begin
                            state_next = SEQ_PUSH;
                            kind_next = KIND_PUSH;
                            count_next = ONE_BYTE;
                            push_buf_next = {FLAGS_OUT, 32'h0};
                        end
                        OP_CALL: begin
                            state_next = SEQ_PUSH;
                            kind_next = KIND_CALL;
                            count_next = CALL_BYTES;
                            push_buf_next = {CTX_IN.pc[7:0], CTX_IN.pc[15:8], 24'h0};
                        end
                        OP_POP: begin
                            state_next = SEQ_POP;
                            kind_next = KIND_POP;
                            count_next = ONE_BYTE;
                        end
                        OP_POP_FLAGS: begin
                            state_next = SEQ_POP;
                            kind_next = KIND_POP_FLAGS;
                            count_next = ONE_BYTE;
                        end
                        OP_RET: begin
                            state_next = SEQ_POP;
                            kind_next = KIND_RET;
                            count_next = CALL_BYTES;
                        end
                        OP_INT_RETURN: begin
                            state_next = SEQ_POP;
                            kind_next = KIND_INT_RETURN;
                            count_next = INT_BYTES;
                        end
                        default: ;
                    endcase
                end
            end
            SEQ_PUSH: begin
                push_buf_next = {push_buf_reg[31:0], 8'h00};
                count_next = count_reg - ONE_BYTE;
                if (count_reg == ONE_BYTE) begin
                    state_next = SEQ_FINISH;
                end
            end
            SEQ_POP: begin
                pop_buf_next = {pop_buf_reg[31:0], stack_rdata};
                count_next = count_reg - ONE_BYTE;
                if (count_reg == ONE_BYTE) begin
                    state_next = SEQ_FINISH;
                end
            end
            SEQ_FINISH: begin
                state_next = SEQ_IDLE;
                done_next = (kind_reg != KIND_INT);
                int_entry_next = (kind_reg == KIND_INT);
                mask_set = (kind_reg == KIND_INT);
                ctx_valid_next = (kind_reg == KIND_RET) || (kind_reg == KIND_INT_RETURN);
                flags_load = (kind_reg == KIND_POP_FLAGS) || (kind_reg == KIND_INT_RETURN);
                if (kind_reg == KIND_INT_RETURN) begin
                    flags_val = pop_buf_reg[39:32];
                end
            end
        endcase
        // New request beats the clear in the same cycle
        pending_next = (pending_reg & ~clear_mask) | IRQ_IN;
        trap_next = (trap_reg & ~trap_clear) | TRAP_IN;
    end

    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SEQ_IDLE;
            kind_reg <= KIND_PUSH;
            count_reg <= 3'h0;
            push_buf_reg <= 40'h0;
            pop_buf_reg <= 40'h0;
            vector_reg <= 4'h0;
            done_reg <= 1'b0;
            ctx_valid_reg <= 1'b0;
            int_entry_reg <= 1'b0;
            pending_reg <= '0;
            trap_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            count_reg <= count_next;
            push_buf_reg <= push_buf_next;
            pop_buf_reg <= pop_buf_next;
            vector_reg <= vector_next;
            done_reg <= done_next;
            ctx_valid_reg <= ctx_valid_next;
            int_entry_reg <= int_entry_next;
            pending_reg <= pending_next;
            trap_reg <= trap_next;
        end
    end

    assign stack_push = (state_reg == SEQ_PUSH);
    assign stack_pop = (state_reg == SEQ_POP);
    assign stack_reload = accept && OP_CODE_IN == OP_STACK_RELOAD;
    assign stack_load_low = accept && OP_CODE_IN == OP_STACK_LOAD_LOW;
    assign stack_wdata = stack_push ? push_buf_reg[39:32] : OPERAND_A_IN;

    cfsp_flags u_flags (
        .clk_in(CLOCK_IN),
        .rst_n_in(rst_n),
        .alu_en_in(accept && op_is_alu),
        .op_in(OP_CODE_IN),
        .a_in(OPERAND_A_IN),
        .b_in(OPERAND_B_IN),
        .mask_set_in(mask_set),
        .load_in(flags_load),
        .load_val_in(flags_val),
        .result_out(RESULT_OUT),
        .flags_out(FLAGS_OUT)
    );

    cfsp_stack u_stack (
        .clk_in(CLOCK_IN),
        .rst_n_in(rst_n),
        .push_in(stack_push),
        .pop_in(stack_pop),
        .reload_in(stack_reload),
        .load_low_in(stack_load_low),
        .wdata_in(stack_wdata),
        .pointer_out(STACK_POINTER_OUT),
        .rdata_out(stack_rdata)
    );

    assign OP_DONE_OUT = done_reg;
    assign CTX_VALID_OUT = ctx_valid_reg;
    assign INT_ENTRY_OUT = int_entry_reg;
    assign INT_VECTOR_OUT = vector_reg;
    assign PENDING_OUT = pending_reg;
    assign POP_DATA_OUT = pop_buf_reg[7:0];
    assign CTX_OUT = '{pc: pop_buf_reg[15:0], a: pop_buf_reg[31:24], x: pop_buf_reg[23:16]};

    assign half_add = ({1'b0, OPERAND_A_IN[3:0]} + {1'b0, OPERAND_B_IN[3:0]}) > 5'h0F;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!rst_n);

    a_half_carry_add: assert property (
        accept && OP_CODE_IN == OP_ADD |=> FLAGS_OUT[FLAG_H] == $past(half_add))
        else $error("half carry wrong after add");
    a_negative_copy: assert property (
        accept && OP_CODE_IN inside {OP_AND, OP_OR, OP_XOR, OP_LOAD} |=> FLAGS_OUT[FLAG_N] == RESULT_OUT[7])
        else $error("negative flag differs from result bit 7");
    a_zero_result: assert property (
        accept && OP_CODE_IN inside {OP_ADD, OP_SUB, OP_LOAD} |=> FLAGS_OUT[FLAG_Z] == (RESULT_OUT == 8'h00))
        else $error("zero flag differs from result");
    a_carry_set: assert property (
        accept && OP_CODE_IN == OP_SET_CARRY |=> FLAGS_OUT[FLAG_C])
        else $error("carry not set");
    a_fixed_bits: assert property (
        FLAGS_OUT[7:5] == FLAGS_FIXED[7:5])
        else $error("upper flag bits not one");
    a_push_decrement: assert property (
        stack_push |=> STACK_POINTER_OUT[6:0] == $past(STACK_POINTER_OUT[6:0]) - 7'h01)
        else $error("pointer did not step down on push");
    a_pointer_upper: assert property (
        STACK_POINTER_OUT[15:7] == STACK_UPPER)
        else $error("pointer upper bits not fixed");
    a_reload_top: assert property (
        stack_reload |=> STACK_POINTER_OUT == STACK_RESET)
        else $error("reload did not reach top");
    a_load_low: assert property (
        stack_load_low |=> STACK_POINTER_OUT[6:0] == $past(OPERAND_A_IN[6:0]))
        else $error("low pointer load failed");
    a_mask_blocks: assert property (
        !trap_reg && FLAGS_OUT[FLAG_I] |-> !take_int)
        else $error("masked request taken");
    a_pending_kept: assert property (
        (|pending_reg) && FLAGS_OUT[FLAG_I] && !trap_reg |=> (|pending_reg))
        else $error("masked request lost");
    a_int_five_bytes: assert property (
        take_int |=> stack_push[*5] ##1 state_reg == SEQ_FINISH ##1 INT_ENTRY_OUT && FLAGS_OUT[FLAG_I])
        else $error("interrupt entry sequence wrong");
    a_enable_int: assert property (
        accept && OP_CODE_IN == OP_ENABLE_INT |=> !FLAGS_OUT[FLAG_I])
        else $error("mask not cleared");
    a_return_restores: assert property (
        state_reg == SEQ_FINISH && kind_reg == KIND_INT_RETURN
        |=> FLAGS_OUT == ($past(pop_buf_reg[39:32]) | FLAGS_FIXED) && CTX_VALID_OUT)
        else $error("return did not restore flags");
endmodule : cfsp_top
`default_nettype wire

// *** rtl/cfsp_pkg.sv ***
package cfsp_pkg;

    // Flag positions inside the condition flags byte
    localparam int FLAG_H = 4;
    localparam int FLAG_I = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;

    // Upper three bits read as one, mask set, undefined bits taken as zero
    localparam logic [7:0] FLAGS_RESET = 8'hE8;
    localparam logic [7:0] FLAGS_FIXED = 8'hE0;

    localparam int STACK_DEPTH = 128;
    localparam int STACK_AW = 7;
    localparam logic [8:0] STACK_UPPER = 9'h003;
    localparam logic [15:0] STACK_RESET = 16'h01FF;

    localparam logic [2:0] ONE_BYTE = 3'h1;
    localparam logic [2:0] CALL_BYTES = 3'h2;
    localparam logic [2:0] INT_BYTES = 3'h5;

    localparam int IRQ_COUNT = 10;
    localparam logic [3:0] TRAP_VECTOR = 4'hA;

    // Flag-affecting operations other than OP_POP_FLAGS and OP_INT_RETURN come first; order matters for decode
    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_LOAD,
        OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_BIT_TEST,
        OP_SET_CARRY, OP_CLEAR_CARRY, OP_ENABLE_INT, OP_DISABLE_INT,
        OP_PUSH, OP_POP, OP_PUSH_FLAGS, OP_POP_FLAGS, OP_CALL, OP_RET,
        OP_INT_RETURN, OP_STACK_RELOAD, OP_STACK_LOAD_LOW
    } cfsp_op_t;

    typedef enum logic [2:0] {
        KIND_INT, KIND_PUSH, KIND_CALL, KIND_POP, KIND_POP_FLAGS, KIND_RET, KIND_INT_RETURN
    } cfsp_kind_t;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_PUSH, SEQ_POP, SEQ_FINISH} cfsp_seq_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] a;
        logic [7:0] x;
    } cfsp_ctx_t;

endpackage : cfsp_pkg

// *** rtl/cfsp_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfsp_flags import cfsp_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic alu_en_in,
    input wire cfsp_op_t op_in,
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    input wire logic mask_set_in,
    input wire logic load_in,
    input wire logic [7:0] load_val_in,
    output logic [7:0] result_out,
    output logic [7:0] flags_out
);
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic [8:0] sum9;
    logic [8:0] diff9;
    logic [4:0] half5;
    logic carry_in;
    logic [7:0] res;
    logic upd_nz;

    always_comb begin
        flags_next = flags_reg;
        result_next = result_reg;
        carry_in = (op_in == OP_ADC || op_in == OP_SBC) ? flags_reg[FLAG_C] : 1'b0;
        sum9 = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
        diff9 = {1'b0, a_in} - {1'b0, b_in} - {8'h00, carry_in};
        half5 = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
        res = a_in;
        upd_nz = 1'b0;
        if (load_in) begin
            flags_next = load_val_in | FLAGS_FIXED;
        end else if (mask_set_in) begin
            flags_next[FLAG_I] = 1'b1;
        end else if (alu_en_in) begin
            unique case (op_in)
                OP_ADD, OP_ADC: begin
                    res = sum9[7:0];
                    flags_next[FLAG_C] = sum9[8];
                    flags_next[FLAG_H] = half5[4];
                    upd_nz = 1'b1;
                end
                OP_SUB, OP_SBC: begin
                    res = diff9[7:0];
                    flags_next[FLAG_C] = diff9[8];
                    upd_nz = 1'b1;
                end
                OP_AND: begin
                    res = a_in & b_in;
                    upd_nz = 1'b1;
                end
                OP_OR: begin
                    res = a_in | b_in;
                    upd_nz = 1'b1;
                end
                OP_XOR: begin
                    res = a_in ^ b_in;
                    upd_nz = 1'b1;
                end
                OP_LOAD: upd_nz = 1'b1;
                OP_SHL: begin
                    res = {a_in[6:0], 1'b0};
                    flags_next[FLAG_C] = a_in[7];
                    upd_nz = 1'b1;
                end
                OP_SHR: begin
                    res = {1'b0, a_in[7:1]};
                    flags_next[FLAG_C] = a_in[0];
                    upd_nz = 1'b1;
                end
                OP_ROL: begin
                    res = {a_in[6:0], flags_reg[FLAG_C]};
                    flags_next[FLAG_C] = a_in[7];
                    upd_nz = 1'b1;
                end
                OP_ROR: begin
                    res = {flags_reg[FLAG_C], a_in[7:1]};
                    flags_next[FLAG_C] = a_in[0];
                    upd_nz = 1'b1;
                end
                OP_BIT_TEST: flags_next[FLAG_C] = a_in[b_in[2:0]];
                OP_SET_CARRY: flags_next[FLAG_C] = 1'b1;
                OP_CLEAR_CARRY: flags_next[FLAG_C] = 1'b0;
                OP_ENABLE_INT: flags_next[FLAG_I] = 1'b0;
                OP_DISABLE_INT: flags_next[FLAG_I] = 1'b1;
                default: ;
            endcase
            if (upd_nz) begin
                result_next = res;
                flags_next[FLAG_N] = res[7];
                flags_next[FLAG_Z] = (res == 8'h00);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_reg <= FLAGS_RESET;
            result_reg <= 8'h00;
        end else begin
            flags_reg <= flags_next;
            result_reg <= result_next;
        end
    end

    assign flags_out = flags_reg;
    assign result_out = result_reg;
endmodule : cfsp_flags
`default_nettype wire

// *** rtl/cfsp_stack.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfsp_stack import cfsp_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic reload_in,
    input wire logic load_low_in,
    input wire logic [7:0] wdata_in,
    output logic [15:0] pointer_out,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [STACK_DEPTH];
    logic [STACK_AW-1:0] ptr_reg;
    logic [STACK_AW-1:0] ptr_next;
    logic [STACK_AW-1:0] ptr_up;

    // Seven-bit arithmetic wraps silently at both limits
    assign ptr_up = ptr_reg + 7'h01;

    always_comb begin
        ptr_next = ptr_reg;
        if (reload_in) begin
            ptr_next = STACK_RESET[STACK_AW-1:0];
        end else if (load_low_in) begin
            ptr_next = wdata_in[STACK_AW-1:0];
        end else if (push_in) begin
            ptr_next = ptr_reg - 7'h01;
        end else if (pop_in) begin
            ptr_next = ptr_up;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ptr_reg <= STACK_RESET[STACK_AW-1:0];
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    // Write at the free slot, then move down
    always_ff @(posedge clk_in) begin
        if (push_in) begin
            mem[ptr_reg] <= wdata_in;
        end
    end

    // Pop reads the slot above the free one
    assign rdata_out = mem[ptr_up];
    assign pointer_out = {STACK_UPPER, ptr_reg};
endmodule : cfsp_stack
`default_nettype wire

// *** tb/cfsp_testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench import cfsp_pkg::*; ;
    logic clk, rst_n, valid, trap, ready, done, ctx_v, entry;
    cfsp_op_t code;
    logic [7:0] opa, opb, res, flags, pdata;
    logic [15:0] sp;
    cfsp_ctx_t ctx, ctx_o;
    logic [3:0] vec;
    logic [IRQ_COUNT-1:0] irq, pend;
    int err_total = 0;
    int check_count = 0;
    cfsp_top dut_u (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .OP_VALID_IN(valid), .OP_CODE_IN(code),
        .OPERAND_A_IN(opa), .OPERAND_B_IN(opb), .CTX_IN(ctx), .IRQ_IN(irq), .TRAP_IN(trap),
        .OP_READY_OUT(ready), .OP_DONE_OUT(done), .RESULT_OUT(res), .FLAGS_OUT(flags),
        .STACK_POINTER_OUT(sp), .POP_DATA_OUT(pdata), .CTX_OUT(ctx_o), .CTX_VALID_OUT(ctx_v),
        .INT_ENTRY_OUT(entry), .INT_VECTOR_OUT(vec), .PENDING_OUT(pend));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic op(input cfsp_op_t c, input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        valid <= 1'b1;
        code <= c;
        opa <= a;
        opb <= b;
        @(negedge clk);
        while (ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        valid <= 1'b0;
        #1;
        while (done !== 1'b1) begin
            @(posedge clk);
            #1;
        end
    endtask : op
    task automatic wait_entry();
        while (entry !== 1'b1) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_entry
    task automatic t_alu();
        op(OP_ADD, 8'h0F, 8'h01);
        check(res, 8'h10, "add res");
        check(flags, 8'hF8, "add half carry");
        op(OP_ADD, 8'hF0, 8'h10);
        check(flags, 8'hEB, "add zero carry");
        op(OP_ADC, 8'h7F, 8'h00);
        check(flags, 8'hFC, "adc negative");
        op(OP_CLEAR_CARRY, 8'h00, 8'h00);
        check(flags, 8'hFC, "clear carry");
        op(OP_SET_CARRY, 8'h00, 8'h00);
        check(flags, 8'hFD, "set carry");
        op(OP_ENABLE_INT, 8'h00, 8'h00);
        check(flags, 8'hF5, "enable int");
        op(OP_DISABLE_INT, 8'h00, 8'h00);
        check(flags, 8'hFD, "disable int");
    endtask : t_alu
    task automatic t_stack();
        op(OP_PUSH, 8'hA5, 8'h00);
        check(sp, 16'h01FE, "push ptr");
        op(OP_POP, 8'h00, 8'h00);
        check({pdata, sp}, 24'hA501FF, "pop");
        op(OP_POP, 8'h00, 8'h00);
        check(sp, 16'h0180, "pop wrap");
        op(OP_PUSH_FLAGS, 8'h00, 8'h00);
        check(sp, 16'h01FF, "push wrap");
        op(OP_CLEAR_CARRY, 8'h00, 8'h00);
        check(flags, 8'hFC, "carry cleared");
        op(OP_POP_FLAGS, 8'h00, 8'h00);
        check({flags, sp}, 24'hFD0180, "pop flags");
        op(OP_STACK_LOAD_LOW, 8'h10, 8'h00);
        check(sp, 16'h0190, "load low");
        op(OP_STACK_RELOAD, 8'h00, 8'h00);
        check(sp, STACK_RESET, "reload");
    endtask : t_stack
    task automatic t_more();
        op(OP_LOAD, 8'h00, 8'h00);
        check({res, flags}, 16'h00FB, "load zero");
        op(OP_SUB, 8'h20, 8'h10);
        check({res, flags}, 16'h10F8, "sub no borrow");
        op(OP_ROL, 8'h81, 8'h00);
        check({res, flags}, 16'h02F9, "rotate left");
        op(OP_AND, 8'hF0, 8'h8F);
        check({res, flags}, 16'h80FD, "and negative");
        op(OP_BIT_TEST, 8'hFB, 8'h02);
        check({res, flags}, 16'h80FC, "bit test");
        op(OP_CALL, 8'h00, 8'h00);
        check(sp, 16'h01FD, "call ptr");
        op(OP_RET, 8'h00, 8'h00);
        check({ctx_o.pc, sp, ctx_v}, {16'h1234, 16'h01FF, 1'b1}, "ret");
    endtask : t_more
    task automatic t_irq();
        @(posedge clk);
        irq <= 10'h004;
        @(posedge clk);
        irq <= 10'h000;
        repeat (3) @(posedge clk);
        #1;
        check({pend, entry}, 11'h008, "held while masked");
        op(OP_ENABLE_INT, 8'h00, 8'h00);
        check(ready, 1'b0, "busy while taking");
        wait_entry();
        check({vec, flags[FLAG_I], pend}, 15'h1400, "entry");
        check(sp, 16'h01FA, "five bytes");
        op(OP_INT_RETURN, 8'h00, 8'h00);
        check({ctx_o, sp, flags[FLAG_I], ctx_v}, {ctx, 16'h01FF, 1'b0, 1'b1}, "return");
        op(OP_DISABLE_INT, 8'h00, 8'h00);
        @(posedge clk);
        trap <= 1'b1;
        @(posedge clk);
        trap <= 1'b0;
        wait_entry();
        check(vec, TRAP_VECTOR, "trap masked");
        op(OP_ENABLE_INT, 8'h00, 8'h00);
        check(flags[FLAG_I], 1'b0, "unmasked in routine");
        op(OP_INT_RETURN, 8'h00, 8'h00);
        check(flags[FLAG_I], 1'b1, "mask restored");
    endtask : t_irq
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    initial begin
        {rst_n, valid, trap, opa, opb, irq} = '0;
        code = OP_ADD;
        ctx = 32'h12345678;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({flags, sp}, {FLAGS_RESET, STACK_RESET}, "reset");
        t_alu();
        t_stack();
        t_more();
        t_irq();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
